// *** csa_ctrl.sv ***
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
// What this block does
// - Gain is one of four codes, 5, 10, 20 or 40 V/V, in a config field.
// - The unidirectional bit bypasses the reference halving divider.
// - A calibrating channel has inputs shorted, load cut and gain 40.
// - Calibration runs a trim of 100 us before the channel counts trimmed.
// - After the trim the calibration setup holds while the request stays.
// - Leaving calibration returns the gain to the configured value.
// - Any calibrating channel forces the reference to bidirectional.
// - That forced reference covers all three channels at once.
// - Transistor sense ties the positive input to the switch node clamp outside calibration.
// - Transistor sense makes the negative input the monitor reference.
// - In transistor sense the amp turns on with valid output after drive.
// - In transistor sense the inputs short when low side is told off.
// - Without transistor sense a config bit picks the monitor reference.
module csa_ctrl
    import csa_pkg::*;
#(
    parameter int NCH = CSA_NCH,
    parameter int TRIM_CYC = CSA_TRIM_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and gate-drive timing
    input wire logic cal_pin,
    input wire logic [NCH-1:0] gate_drive_window,
    input wire logic [NCH-1:0] lowside_on_cmd,
    // Analog controls
    output logic [1:0] amp_gain [NCH],
    output logic vref_divider_bypass,
    output logic [NCH-1:0] amp_inputs_short,
    output logic [NCH-1:0] amp_load_disconnect,
    output logic [NCH-1:0] amp_pos_to_phase_switch_node,
    output logic [NCH-1:0] lowside_monitor_ref_neg,
    output logic [NCH-1:0] amp_enable,
    output logic [NCH-1:0] amp_analog_output_valid
);
    // ==========================================================
    // Registers
    // ==========================================================
    logic [31:0] cfg_r, cfg_nxt;
    logic [NCH-1:0] calreq_r, calreq_nxt;
    logic aw_hold_r, aw_hold_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    logic cal_pin_s;
    logic [NCH-1:0] window_s, lson_s;
    logic [NCH-1:0] window_d_r, lson_d_r;
    logic [NCH-1:0] fet_valid_r, fet_valid_nxt;
    logic [NCH-1:0] fet_short_r, fet_short_nxt;

    logic [NCH-1:0] amp_offset_cal_request;
    logic [NCH-1:0] in_cal, trim_busy, trim_done;
    logic [1:0] cfg_gain;
    logic cfg_unidir, transistor_voltage_sense_sel, lowside_monitor_ref_sel;
    logic any_cal;
    logic wr_go;

    // Byte-lane merge for a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    csa_sync3 #(.W(1 + 2 * NCH)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in({cal_pin, gate_drive_window, lowside_on_cmd}),
        .sync_out({cal_pin_s, window_s, lson_s})
    );

    // ==========================================================
    // Calibration channels
    // ==========================================================
    assign amp_offset_cal_request = calreq_r | {NCH{cal_pin_s}};

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        csa_cal_chan #(.TRIM_CYC(TRIM_CYC)) u_cal (
            .core_clk(core_clk),
            .resetn(resetn),
            .cal_req(amp_offset_cal_request[c]),
            .in_cal(in_cal[c]),
            .trim_busy(trim_busy[c]),
            .trim_done(trim_done[c])
        );
    end

    // ==========================================================
    // Config decode
    // ==========================================================
    assign cfg_gain = cfg_r[CSA_CFG_GAIN_LSB +: 2];
    assign cfg_unidir = cfg_r[CSA_CFG_UNIDIR_BIT];
    assign transistor_voltage_sense_sel = cfg_r[CSA_CFG_FETSENSE_BIT];
    assign lowside_monitor_ref_sel = cfg_r[CSA_CFG_LSREF_BIT];
    assign any_cal = |in_cal;

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

    always_comb begin
        cfg_nxt = cfg_r;
        calreq_nxt = calreq_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = CSA_RESP_OKAY;
            case ({awaddr_r[7:2], 2'b00})
                CSA_OFF_CONFIG: begin
                    cfg_nxt = lane_merge(cfg_r, wdata_r, wstrb_r)
                              & CSA_CFG_MASK;
                end
                CSA_OFF_CAL: begin
                    if (wstrb_r[0]) begin
                        calreq_nxt = wdata_r[NCH-1:0];
                    end
                end
                CSA_OFF_STATUS, CSA_OFF_PHASE: begin
                    // Read-only words ignore writes
                end
                default: begin
                    bresp_nxt = CSA_RESP_SLVERR;
                end
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_nxt = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = CSA_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                CSA_OFF_CONFIG: rdata_nxt = cfg_r;
                CSA_OFF_CAL: rdata_nxt[NCH-1:0] = calreq_r;
                CSA_OFF_STATUS: begin
                    rdata_nxt[NCH-1:0] = trim_busy;
                    rdata_nxt[8 +: NCH] = trim_done;
                    rdata_nxt[16] = cal_pin_s;
                    rdata_nxt[17] = vref_divider_bypass;
                end
                CSA_OFF_PHASE: begin
                    rdata_nxt[NCH-1:0] = amp_enable;
                    rdata_nxt[8 +: NCH] = amp_analog_output_valid;
                    rdata_nxt[16 +: NCH] = amp_inputs_short;
                end
                default: rresp_nxt = CSA_RESP_SLVERR;
            endcase
        end
    end

    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ==========================================================
    // Transistor-voltage sense timing
    // ==========================================================
    always_comb begin
        fet_valid_nxt = fet_valid_r;
        fet_short_nxt = fet_short_r;
        for (int c = 0; c < NCH; c++) begin
            if (!transistor_voltage_sense_sel || !lson_s[c]) begin
                fet_valid_nxt[c] = 1'b0;
            end else if (window_d_r[c] && !window_s[c]) begin
                fet_valid_nxt[c] = 1'b1;
            end
            if (!transistor_voltage_sense_sel) begin
                fet_short_nxt[c] = 1'b0;
            end else if (lson_d_r[c] && !lson_s[c]) begin
                fet_short_nxt[c] = 1'b1;
            end else if (!lson_d_r[c] && lson_s[c]) begin
                fet_short_nxt[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CSA_CFG_RESET;
            calreq_r <= '0;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= CSA_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= CSA_RESP_OKAY;
            window_d_r <= '0;
            lson_d_r <= '0;
            fet_valid_r <= '0;
            fet_short_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            calreq_r <= calreq_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            window_d_r <= window_s;
            lson_d_r <= lson_s;
            fet_valid_r <= fet_valid_nxt;
            fet_short_r <= fet_short_nxt;
        end
    end

    // ==========================================================
    // Analog control outputs
    // ==========================================================
    // Controller is expected to calibrate with the bridge idle
    assign vref_divider_bypass = cfg_unidir && !any_cal;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            // Gain is derived, so the configured value comes back on exit
            amp_gain[c] = in_cal[c] ? CSA_GAIN_40 : cfg_gain;
            amp_inputs_short[c] = in_cal[c] || fet_short_r[c];
            amp_load_disconnect[c] = in_cal[c];
            amp_pos_to_phase_switch_node[c] = transistor_voltage_sense_sel
                                              && !in_cal[c];
            amp_enable[c] = transistor_voltage_sense_sel ? fet_valid_r[c]
                                                         : 1'b1;
            amp_analog_output_valid[c] = !in_cal[c] && (amp_enable[c]
                                         && !fet_short_r[c]);
            lowside_monitor_ref_neg[c] = transistor_voltage_sense_sel
                                         || lowside_monitor_ref_sel;
        end
    end
endmodule // csa_ctrl

// *** csa_pkg.sv ***
package csa_pkg;
    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CSA_OFF_CONFIG = 8'h00;
    localparam logic [7:0] CSA_OFF_CAL = 8'h04;
    localparam logic [7:0] CSA_OFF_STATUS = 8'h08;
    localparam logic [7:0] CSA_OFF_PHASE = 8'h0C;

    // ==========================================================
    // Config fields
    // ==========================================================
    localparam int CSA_CFG_GAIN_LSB = 0;
    localparam int CSA_CFG_UNIDIR_BIT = 2;
    localparam int CSA_CFG_FETSENSE_BIT = 3;
    localparam int CSA_CFG_LSREF_BIT = 4;
    localparam logic [31:0] CSA_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CSA_CFG_MASK = 32'h0000_001F;

    // ==========================================================
    // Gain codes
    // ==========================================================
    localparam logic [1:0] CSA_GAIN_5 = 2'h0;
    localparam logic [1:0] CSA_GAIN_10 = 2'h1;
    localparam logic [1:0] CSA_GAIN_20 = 2'h2;
    localparam logic [1:0] CSA_GAIN_40 = 2'h3;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CSA_CLK_MHZ = 100;
    localparam int CSA_TRIM_US = 100;
    localparam int CSA_TRIM_CYC = CSA_TRIM_US * CSA_CLK_MHZ;
    localparam int CSA_NCH = 3;

    // ==========================================================
    // Channel states
    // ==========================================================
    typedef enum logic [2:0] {
        CSA_ST_IDLE = 3'b001,
        CSA_ST_TRIM = 3'b010,
        CSA_ST_HOLD = 3'b100
    } csa_cal_st_t;

    // Protocol responses
    localparam logic [1:0] CSA_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSA_RESP_SLVERR = 2'h2;
endpackage

// *** csa_sync3.sv ***
`timescale 1ns/10ps
module csa_sync3
    import csa_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_r, s2_r, s3_r, out_r;
    logic [W-1:0] out_nxt;

    // ==========================================================
    // Accept a change once stages two and three agree
    // ==========================================================
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                out_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign sync_out = out_r;
endmodule // csa_sync3

// *** csa_cal_chan.sv ***
`timescale 1ns/10ps
module csa_cal_chan
    import csa_pkg::*;
#(
    parameter int TRIM_CYC = CSA_TRIM_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Request
    input wire logic cal_req,
    // State
    output logic in_cal,
    output logic trim_busy,
    output logic trim_done
);
    localparam int CW = $clog2(TRIM_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(TRIM_CYC - 1);

    csa_cal_st_t st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    // ==========================================================
    // Trim sequence
    // ==========================================================
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            CSA_ST_IDLE: begin
                cnt_nxt = '0;
                if (cal_req) begin
                    st_nxt = CSA_ST_TRIM;
                end
            end
            CSA_ST_TRIM: begin
                // Dropping the request aborts the trim
                if (!cal_req) begin
                    st_nxt = CSA_ST_IDLE;
                end else if (cnt_r == CNT_LAST) begin
                    st_nxt = CSA_ST_HOLD;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            CSA_ST_HOLD: begin
                if (!cal_req) begin
                    st_nxt = CSA_ST_IDLE;
                end
            end
            default: begin
                st_nxt = CSA_ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= CSA_ST_IDLE;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign in_cal = (st_r != CSA_ST_IDLE);
    assign trim_busy = (st_r == CSA_ST_TRIM);
    assign trim_done = (st_r == CSA_ST_HOLD);
endmodule // csa_cal_chan

// *** csa_ctrl_properties.sv ***
`timescale 1ns/10ps
module csa_ctrl_properties
    import csa_pkg::*;
#(
    parameter int NCH = CSA_NCH,
    parameter int TRIM_CYC = CSA_TRIM_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Pins
    input wire logic cal_pin,
    input wire logic [NCH-1:0] gate_drive_window,
    input wire logic [NCH-1:0] lowside_on_cmd,
    // Analog controls
    input wire logic [1:0] amp_gain [NCH],
    input wire logic vref_divider_bypass,
    input wire logic [NCH-1:0] amp_inputs_short,
    input wire logic [NCH-1:0] amp_load_disconnect,
    input wire logic [NCH-1:0] amp_pos_to_phase_switch_node,
    input wire logic [NCH-1:0] lowside_monitor_ref_neg,
    input wire logic [NCH-1:0] amp_enable,
    input wire logic [NCH-1:0] amp_analog_output_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Per channel
    // ==========================================================
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        AST_CAL_GAIN40: assert property (
            amp_load_disconnect[i] |-> amp_gain[i] == CSA_GAIN_40)
            else $error("calibrating channel not at gain 40");
        AST_CAL_SHORT: assert property (
            amp_load_disconnect[i] |-> amp_inputs_short[i])
            else $error("calibrating channel inputs not shorted");
        AST_FET_REF: assert property (
            amp_pos_to_phase_switch_node[i] |-> lowside_monitor_ref_neg[i])
            else $error("sense mode monitor reference not negative");
        // Six quiet cycles outlast the input sync
        AST_FET_OFF_SHORT: assert property (
            $fell(lowside_on_cmd[i]) ##1
            (amp_pos_to_phase_switch_node[i] && !lowside_on_cmd[i])[*6]
            |-> amp_inputs_short[i])
            else $error("inputs not shorted after low side off");
        AST_FET_VALID: assert property (
            $fell(gate_drive_window[i]) ##1
            (amp_pos_to_phase_switch_node[i] && lowside_on_cmd[i] &&
            !gate_drive_window[i])[*6]
            |-> amp_enable[i] && amp_analog_output_valid[i])
            else $error("output not valid after drive window");
    end
    // ==========================================================
    // Shared
    // ==========================================================
    AST_CAL_VREF: assert property (
        |amp_load_disconnect |-> !vref_divider_bypass)
        else $error("reference not bidirectional in calibration");
    AST_PIN_ENTRY: assert property (
        $rose(cal_pin) ##1 cal_pin[*6] |-> &amp_load_disconnect)
        else $error("pin did not start calibration");
    AST_PIN_HOLD: assert property (
        cal_pin[*8] |-> &amp_load_disconnect && &amp_inputs_short)
        else $error("calibration setup dropped while pin high");
    AST_BVALID_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    AST_RDATA_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
endmodule // csa_ctrl_properties

bind csa_ctrl csa_ctrl_properties #(.NCH(NCH), .TRIM_CYC(TRIM_CYC)) u_props (
    .core_clk(core_clk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .cal_pin(cal_pin), .gate_drive_window(gate_drive_window),
    .lowside_on_cmd(lowside_on_cmd), .amp_gain(amp_gain),
    .vref_divider_bypass(vref_divider_bypass),
    .amp_inputs_short(amp_inputs_short),
    .amp_load_disconnect(amp_load_disconnect),
    .amp_pos_to_phase_switch_node(amp_pos_to_phase_switch_node),
    .lowside_monitor_ref_neg(lowside_monitor_ref_neg),
    .amp_enable(amp_enable), .amp_analog_output_valid(amp_analog_output_valid)
);

// *** csa_host_model.sv ***
`timescale 1ns/10ps
module csa_host_model
    import csa_pkg::*;
#(
    parameter int NCH = CSA_NCH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Bench commands
    input wire logic cal_cmd,
    input wire logic pwm_run,
    // Pins to the block, and the switching phase to the bench
    output logic cal_pin,
    output logic [NCH-1:0] gate_drive_window,
    output logic [NCH-1:0] lowside_on_cmd,
    output logic [4:0] phase_r
);
    logic [4:0] phase_nxt;
    logic cal_nxt;
    // ==========================================================
    // Switching period and calibration pin
    // ==========================================================
    always_comb begin
        phase_nxt = pwm_run ? phase_r + 5'h01 : 5'h00;
        // Calibration withheld while the bridge switches
        cal_nxt = cal_cmd && !pwm_run;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 5'h00;
            cal_pin <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cal_pin <= cal_nxt;
        end
    end
    assign gate_drive_window = {NCH{pwm_run && phase_r < 5'h04}};
    assign lowside_on_cmd = {NCH{pwm_run && phase_r < 5'h14}};
endmodule // csa_host_model

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import csa_pkg::*;
    localparam int TC = 20;
    logic core_clk, resetn, cal_cmd, pwm_run, cal_pin;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdv, cfg_m, rnd, d;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [2:0] gdw, ls_on, shrt, disc, pos, refn, en, vld, masks [2];
    logic [1:0] amp_gain [CSA_NCH];
    logic bypass;
    logic [4:0] phase;
    int fails, cmp_count;
    csa_ctrl #(.TRIM_CYC(TC)) uut (.core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cal_pin(cal_pin), .gate_drive_window(gdw),
        .lowside_on_cmd(ls_on), .amp_gain(amp_gain),
        .vref_divider_bypass(bypass), .amp_inputs_short(shrt),
        .amp_load_disconnect(disc), .amp_pos_to_phase_switch_node(pos),
        .lowside_monitor_ref_neg(refn), .amp_enable(en),
        .amp_analog_output_valid(vld));
    csa_host_model u_host (.core_clk(core_clk), .resetn(resetn),
        .cal_cmd(cal_cmd), .pwm_run(pwm_run), .cal_pin(cal_pin),
        .gate_drive_window(gdw), .lowside_on_cmd(ls_on), .phase_r(phase));
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            rsp = bresp;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk(bvalid, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            rdv = rdata;
            rsp = rresp;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        chk(rvalid, 1'b1);
    endtask
    // Expected outputs for a calibration mask
    task automatic chk_out(input logic [2:0] m);
        @(negedge core_clk);
        for (int i = 0; i < CSA_NCH; i++) begin
            chk(amp_gain[i], m[i] ? CSA_GAIN_40 : cfg_m[1:0]);
        end
        chk(disc, m);
        chk(shrt, m);
        chk(bypass, (m != 3'h0) ? 1'b0 : cfg_m[2]);
        chk(refn, {3{cfg_m[4]}});
    endtask
    task automatic wait_phase(input logic [4:0] p);
        int n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (phase !== p && n < 100);
    endtask
    task tally_and_finish;
        $display("Counts: fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog, sequence
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #300000;
        chk(1'b0, 1'b1);
        tally_and_finish();
    end
    initial begin
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {resetn, cal_cmd, pwm_run, fails, cmp_count} = '0;
        rnd = 32'h8;
        cfg_m = 32'h0;
        masks = '{3'h1, 3'h6};
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        chk_out(3'h0);
        chk(en, 3'h7);
        rd(CSA_OFF_CONFIG);
        chk(rdv, CSA_CFG_RESET);
        for (int g = 0; g < 4; g++) begin
            d = (xs() & 32'hFFFF_FFF4) | g;
            wr(CSA_OFF_CONFIG, d);
            cfg_m = d & CSA_CFG_MASK;
            rd(CSA_OFF_CONFIG);
            chk(rdv, cfg_m);
            chk_out(3'h0);
        end
        wr(8'h10, 32'h1);
        chk(rsp, CSA_RESP_SLVERR);
        rd(8'h14);
        chk(rsp, CSA_RESP_SLVERR);
        wr(CSA_OFF_STATUS, 32'hFFFF_FFFF);
        chk(rsp, CSA_RESP_OKAY);
        cfg_m = 32'h5;
        wr(CSA_OFF_CONFIG, cfg_m);
        for (int k = 0; k < 2; k++) begin
            wr(CSA_OFF_CAL, {29'h0, masks[k]});
            chk_out(masks[k]);
            rd(CSA_OFF_STATUS);
            chk(rdv[10:0], {8'h0, masks[k]});
            repeat (TC + 4) @(posedge core_clk);
            rd(CSA_OFF_STATUS);
            chk(rdv[10:0], {masks[k], 8'h0});
            chk_out(masks[k]);
            wr(CSA_OFF_CAL, 32'h0);
            chk_out(3'h0);
        end
        cal_cmd <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk_out(3'h7);
        cal_cmd <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk_out(3'h0);
        cfg_m = 32'h8;
        wr(CSA_OFF_CONFIG, cfg_m);
        @(negedge core_clk);
        chk(pos, 3'h7);
        chk(refn, 3'h7);
        @(posedge core_clk);
        pwm_run <= 1'b1;
        cal_cmd <= 1'b1;
        wait_phase(5'h0E);
        chk(disc, 3'h0);
        chk({en, vld, shrt}, {3'h7, 3'h7, 3'h0});
        wait_phase(5'h1E);
        chk({vld, shrt}, {3'h0, 3'h7});
        tally_and_finish();
    end
endmodule // testbench
